// *** core/sbcmo_pkg.sv ***
package sbcmo_pkg;
  // ==========================================================
  // Operating states
  typedef enum logic [2:0] {
    SBCMO_INIT     = 3'h0,
    SBCMO_NORMAL   = 3'h1,
    SBCMO_STOP     = 3'h2,
    SBCMO_SLEEP    = 3'h3,
    SBCMO_RESTART  = 3'h4,
    SBCMO_FAILSAFE = 3'h5
  } sbcmo_state_e;

  // ==========================================================
  // Codes of the operating-state select field
  localparam logic [1:0] SEL_NORMAL = 2'h0;
  localparam logic [1:0] SEL_SLEEP = 2'h1;
  localparam logic [1:0] SEL_STOP = 2'h2;
  localparam logic [1:0] SEL_SOFT_RESET = 2'h3;

  // ==========================================================
  // Serial frame layout: data[15:8], write[7], address[6:0]
  localparam int FRM_ADDR_LSB = 0;
  localparam int FRM_ADDR_MSB = 6;
  localparam int FRM_WR_BIT = 7;
  localparam int FRM_DATA_LSB = 8;
  localparam int FRM_DATA_MSB = 15;
  localparam int SEL_LSB = 6;
  localparam int SEL_MSB = 7;
  localparam logic [6:0] ADDR_MODE_CTRL = 7'h01;
  localparam logic [6:0] ADDR_WD_CTRL = 7'h02;
  localparam logic [6:0] ADDR_STATUS = 7'h40;
  localparam logic [5:0] MODE_LOW_ZERO = 6'h00;
  localparam logic [4:0] STAT_PAD_ZERO = 5'h00;
  localparam logic [15:0] RD_RESET = 16'h0000;

  // ==========================================================
  // Timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int RESET_DELAY_US = 10;
  localparam int RESET_DELAY_CYC =
    (RESET_DELAY_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int LONG_WIN_MS = 200;
  localparam int WD_PERIOD_MS = 20;
  localparam int LONG_WIN_CYC = LONG_WIN_MS * 100000;
  localparam int WD_PERIOD_CYC = WD_PERIOD_MS * 100000;
  localparam int RD_CNT_W = 16;
  localparam int WD_CNT_W = 32;
endpackage

// *** core/sbcmo_ctl_if.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Control links between the mode machine and its helpers
interface sbcmo_ctl_if;
  logic in_init;
  logic wd_run;
  logic wd_kick;
  logic wd_reload;
  logic wd_fail;
  logic dev_mode;
  logic cfg_fail_safe;
  modport fsm (output in_init, wd_run, wd_kick, wd_reload,
               input wd_fail, dev_mode, cfg_fail_safe);
  modport wdg (input wd_run, wd_kick, wd_reload, dev_mode,
               output wd_fail);
  modport cfg (input in_init, output dev_mode, cfg_fail_safe);
endinterface
`default_nettype wire

// *** core/sbcmo_watchdog_unit.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Watchdog counter with long open window after reload
module sbcmo_watchdog_unit #(
  parameter int LONG_WIN = sbcmo_pkg::LONG_WIN_CYC,
  parameter int PERIOD = sbcmo_pkg::WD_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Control link
  sbcmo_ctl_if.wdg ctl
);
  typedef struct packed {
    logic [sbcmo_pkg::WD_CNT_W-1:0] cnt;
    logic fail;
  } sbcmo_wd_s;

  sbcmo_wd_s st_ff;
  sbcmo_wd_s nxt_st;

  // Countdown; development mode freezes it so no trigger is needed
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.fail = 1'b0;
    if (ctl.wd_reload)
    begin
      nxt_st.cnt = sbcmo_pkg::WD_CNT_W'(LONG_WIN); // [R16]
    end
    else if (!ctl.wd_run || ctl.dev_mode)
    begin
      nxt_st.cnt = st_ff.cnt; // [R9]
    end
    else if (ctl.wd_kick)
    begin
      nxt_st.cnt = sbcmo_pkg::WD_CNT_W'(PERIOD);
    end
    else if (st_ff.cnt == '0)
    begin
      nxt_st.fail = 1'b1; // [R16]
      nxt_st.cnt = sbcmo_pkg::WD_CNT_W'(PERIOD);
    end
    else
    begin
      nxt_st.cnt = st_ff.cnt - 1'b1;
    end
  end

  // State register
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '{cnt: sbcmo_pkg::WD_CNT_W'(LONG_WIN), fail: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign ctl.wd_fail = st_ff.fail;
endmodule
`default_nettype wire

// *** core/sbcmo_strap_sampler.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Captures debug strap and failure-behaviour strap during Init
module sbcmo_strap_sampler (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Strap pins
  input wire logic debug_strap_n,
  input wire logic cfg_strap,
  // Control link
  sbcmo_ctl_if.cfg ctl
);
  typedef struct packed {
    logic dev_mode;
    logic fail_safe;
  } sbcmo_cfg_s;

  sbcmo_cfg_s st_ff;
  sbcmo_cfg_s nxt_st;

  // Track straps only in Init; last value is kept afterwards
  always_comb
  begin
    nxt_st = st_ff;
    if (ctl.in_init)
    begin
      nxt_st.dev_mode = ~debug_strap_n; // [R10]
      nxt_st.fail_safe = ~cfg_strap; // [R11]
    end
  end

  // Defaults: normal operation, failure leads to fail-safe
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '{dev_mode: 1'b0, fail_safe: 1'b1};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  assign ctl.dev_mode = st_ff.dev_mode;
  assign ctl.cfg_fail_safe = st_ff.fail_safe;
endmodule
`default_nettype wire

// *** core/sbc_operating_mode_fsm.sv ***
// Notes on behaviour
// [R1] Six states only: Init, Normal, Stop, Sleep, Restart, Fail-Safe.
// [R2] Power-up and soft reset both lead into Init.
// [R3] Stop keeps the main regulator output on.
// [R4] Sleep turns the main regulator output off.
// [R5] Wake in Sleep/Fail-Safe or a failure enters Restart; MCU held in reset.
// [R6] Restart goes to Normal after reset delay once failure is gone.
// [R7] Critical failures enter Fail-Safe with main regulator off.
// [R8] Fail-Safe ends on wake, or when overtemperature has cleared if overtemperature was the cause.
// [R9] Development mode freezes the watchdog counter; all states reachable.
// [R10] Development mode only when debug strap is low during Init.
// [R11] Watchdog failure behaviour is picked by a sampled external strap.
// [R12] Configuration and status travel in 16-bit serial frames.
// [R13] Writing the state select field requests a state change.
// [R14] State select field clears in Restart, so it shows the current state.
// [R15] Any frame in Init, even illegal, moves to Normal; a soft-reset write keeps Init instead.
// [R16] Init starts a long watchdog window; missing trigger goes to Restart.
// [R17] Wake events in Init are ignored and dropped.
// [R18] Other failures in Normal or Stop go to Restart.
`timescale 1ns/1ns
`default_nettype none
module sbc_operating_mode_fsm #(
  parameter int WAKE_W = 3,
  parameter int LONG_WIN = sbcmo_pkg::LONG_WIN_CYC,
  parameter int WD_PERIOD = sbcmo_pkg::WD_PERIOD_CYC
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Decoded serial frames from the microcontroller
  input wire logic spi_frame_valid,
  input wire logic [15:0] spi_frame,
  output logic [15:0] spi_rd_data,
  output logic spi_rd_valid,
  output logic spi_error,
  // Wake sources
  input wire logic can_wake,
  input wire logic lin_wake,
  input wire logic [WAKE_W-1:0] wake_inputs,
  // Failure sources
  input wire logic regulator_uv,
  input wire logic overtemp,
  // Straps
  input wire logic debug_strap_n,
  input wire logic cfg_strap,
  // Supply and reset control
  output logic main_regulator_output,
  output logic mcu_reset_b,
  // Status
  output logic [2:0] operating_state,
  output logic [1:0] operating_state_select,
  output logic dev_mode
);
  // ==========================================================
  // State record
  typedef struct packed {
    sbcmo_pkg::sbcmo_state_e state;
    logic [sbcmo_pkg::RD_CNT_W-1:0] rd_cnt;
    logic [1:0] sel;
    logic fs_by_ot;
    logic [15:0] rd_data;
    logic rd_valid;
    logic spi_err;
    logic reg_on;
    logic mcu_rst_b;
    logic in_init;
    logic wd_reload;
  } sbcmo_fsm_s;

  sbcmo_fsm_s st_ff;
  sbcmo_fsm_s nxt_st;
  sbcmo_ctl_if ctl ();

  // ==========================================================
  // Frame field helpers
  function automatic logic [6:0] frm_addr(input logic [15:0] f);
    frm_addr = f[sbcmo_pkg::FRM_ADDR_MSB:sbcmo_pkg::FRM_ADDR_LSB];
  endfunction

  function automatic logic frm_write_to(input logic [15:0] f,
                                        input logic [6:0] a);
    frm_write_to = f[sbcmo_pkg::FRM_WR_BIT] && (frm_addr(f) == a);
  endfunction

  // ==========================================================
  // Decoded events of this cycle
  logic any_wake;
  logic wr_mode;
  logic wr_wd;
  logic frm_legal;
  logic [1:0] req_sel;
  logic [7:0] frm_data;

  // Wake, frame and request decode
  always_comb
  begin
    any_wake = can_wake || lin_wake || (|wake_inputs);
    frm_data = spi_frame[sbcmo_pkg::FRM_DATA_MSB:sbcmo_pkg::FRM_DATA_LSB];
    req_sel = frm_data[sbcmo_pkg::SEL_MSB:sbcmo_pkg::SEL_LSB];
    wr_mode = spi_frame_valid &&
              frm_write_to(spi_frame, sbcmo_pkg::ADDR_MODE_CTRL); // [R13]
    wr_wd = spi_frame_valid &&
            frm_write_to(spi_frame, sbcmo_pkg::ADDR_WD_CTRL);
    frm_legal = (frm_addr(spi_frame) == sbcmo_pkg::ADDR_MODE_CTRL) ||
                (frm_addr(spi_frame) == sbcmo_pkg::ADDR_WD_CTRL) ||
                (frm_addr(spi_frame) == sbcmo_pkg::ADDR_STATUS &&
                 !spi_frame[sbcmo_pkg::FRM_WR_BIT]); // [R12]
  end

  // ==========================================================
  // Next-state logic
  always_comb
  begin
    nxt_st = st_ff;
    nxt_st.rd_valid = 1'b0;
    nxt_st.wd_reload = 1'b0;

    // Frame answer: read-back of the addressed register
    if (spi_frame_valid)
    begin
      nxt_st.rd_valid = 1'b1; // [R12]
      nxt_st.spi_err = !frm_legal;
      case (frm_addr(spi_frame))
        sbcmo_pkg::ADDR_MODE_CTRL:
          nxt_st.rd_data = {st_ff.sel, sbcmo_pkg::MODE_LOW_ZERO,
                            8'h00};
        sbcmo_pkg::ADDR_STATUS:
          nxt_st.rd_data = {sbcmo_pkg::STAT_PAD_ZERO, st_ff.state,
                            ctl.dev_mode, ctl.cfg_fail_safe,
                            regulator_uv, overtemp, 4'h0};
        default:
          nxt_st.rd_data = sbcmo_pkg::RD_RESET;
      endcase
    end

    case (st_ff.state)
      // Waiting for the first frame; wakes are simply not looked at
      sbcmo_pkg::SBCMO_INIT:
      begin
        if (ctl.wd_fail || regulator_uv)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_RESTART; // [R16]
        end
        else if (wr_mode && req_sel == sbcmo_pkg::SEL_SOFT_RESET)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_INIT;
          nxt_st.wd_reload = 1'b1;
        end
        else if (spi_frame_valid)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_NORMAL; // [R15] [R17]
        end
      end

      // Normal and Stop share their failure handling
      sbcmo_pkg::SBCMO_NORMAL,
      sbcmo_pkg::SBCMO_STOP:
      begin
        if (overtemp)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_FAILSAFE; // [R7]
          nxt_st.fs_by_ot = 1'b1;
        end
        else if (ctl.wd_fail && ctl.cfg_fail_safe)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_FAILSAFE; // [R7] [R11]
          nxt_st.fs_by_ot = 1'b0;
        end
        else if (ctl.wd_fail || regulator_uv)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_RESTART; // [R5] [R18]
        end
        else if (wr_mode)
        begin
          nxt_st.sel = req_sel; // [R13]
          case (req_sel)
            sbcmo_pkg::SEL_SLEEP:
              nxt_st.state = sbcmo_pkg::SBCMO_SLEEP;
            sbcmo_pkg::SEL_STOP:
              nxt_st.state = sbcmo_pkg::SBCMO_STOP;
            sbcmo_pkg::SEL_SOFT_RESET:
            begin
              nxt_st.state = sbcmo_pkg::SBCMO_INIT; // [R2]
              nxt_st.sel = sbcmo_pkg::SEL_NORMAL;
              nxt_st.wd_reload = 1'b1;
            end
            default:
              nxt_st.state = sbcmo_pkg::SBCMO_NORMAL;
          endcase
        end
      end

      // Regulator off; only a wake or overheating ends it
      sbcmo_pkg::SBCMO_SLEEP:
      begin
        if (overtemp)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_FAILSAFE;
          nxt_st.fs_by_ot = 1'b1;
        end
        else if (any_wake)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_RESTART; // [R5]
        end
      end

      // Microcontroller held in reset until delay runs out
      sbcmo_pkg::SBCMO_RESTART:
      begin
        nxt_st.sel = sbcmo_pkg::SEL_NORMAL; // [R14]
        nxt_st.wd_reload = 1'b1;
        if (overtemp)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_FAILSAFE;
          nxt_st.fs_by_ot = 1'b1;
        end
        else if (regulator_uv)
        begin
          nxt_st.rd_cnt =
            sbcmo_pkg::RD_CNT_W'(sbcmo_pkg::RESET_DELAY_CYC - 1); // [R6]
        end
        else if (st_ff.rd_cnt == '0)
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_NORMAL; // [R6]
        end
        else
        begin
          nxt_st.rd_cnt = st_ff.rd_cnt - 1'b1;
        end
      end

      // Safe state until a wake; overheating exit only if it was the cause
      sbcmo_pkg::SBCMO_FAILSAFE:
      begin
        if (any_wake || (st_ff.fs_by_ot && !overtemp))
        begin
          nxt_st.state = sbcmo_pkg::SBCMO_RESTART; // [R8] [R5]
          nxt_st.fs_by_ot = 1'b0;
        end
      end

      default:
        nxt_st.state = sbcmo_pkg::SBCMO_INIT; // [R1]
    endcase

    // Restart delay always starts full on entry
    if (nxt_st.state == sbcmo_pkg::SBCMO_RESTART &&
        st_ff.state != sbcmo_pkg::SBCMO_RESTART)
    begin
      nxt_st.rd_cnt =
        sbcmo_pkg::RD_CNT_W'(sbcmo_pkg::RESET_DELAY_CYC - 1);
    end

    // Registered pin levels follow the next state
    case (nxt_st.state)
      sbcmo_pkg::SBCMO_SLEEP:
        nxt_st.reg_on = 1'b0; // [R4]
      sbcmo_pkg::SBCMO_FAILSAFE:
        nxt_st.reg_on = 1'b0; // [R7]
      sbcmo_pkg::SBCMO_STOP:
        nxt_st.reg_on = 1'b1; // [R3]
      default:
        nxt_st.reg_on = 1'b1;
    endcase
    nxt_st.mcu_rst_b =
      (nxt_st.state != sbcmo_pkg::SBCMO_RESTART) &&
      (nxt_st.state != sbcmo_pkg::SBCMO_FAILSAFE); // [R5]
    nxt_st.in_init = (nxt_st.state == sbcmo_pkg::SBCMO_INIT);
  end

  // ==========================================================
  // State register; power-up lands in Init
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st_ff <= '{state: sbcmo_pkg::SBCMO_INIT, // [R2]
                 rd_cnt: '0,
                 sel: sbcmo_pkg::SEL_NORMAL,
                 fs_by_ot: 1'b0,
                 rd_data: sbcmo_pkg::RD_RESET,
                 rd_valid: 1'b0,
                 spi_err: 1'b0,
                 reg_on: 1'b1,
                 mcu_rst_b: 1'b1,
                 in_init: 1'b1,
                 wd_reload: 1'b0};
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ==========================================================
  // Helper links; watchdog idle while regulator is off or in reset
  assign ctl.in_init = st_ff.in_init;
  assign ctl.wd_reload = st_ff.wd_reload;
  assign ctl.wd_kick = wr_wd;
  assign ctl.wd_run = (st_ff.state == sbcmo_pkg::SBCMO_INIT) ||
                      (st_ff.state == sbcmo_pkg::SBCMO_NORMAL) ||
                      (st_ff.state == sbcmo_pkg::SBCMO_STOP);

  // Watchdog counter
  sbcmo_watchdog_unit #(
    .LONG_WIN(LONG_WIN),
    .PERIOD(WD_PERIOD)
  ) u_wdg (
    .clk(clk),
    .rst_b(rst_b),
    .ctl(ctl.wdg)
  );

  // Strap capture
  sbcmo_strap_sampler u_cfg (
    .clk(clk),
    .rst_b(rst_b),
    .debug_strap_n(debug_strap_n),
    .cfg_strap(cfg_strap),
    .ctl(ctl.cfg)
  );

  // ==========================================================
  // Outputs, all from flip-flops
  assign spi_rd_data = st_ff.rd_data;
  assign spi_rd_valid = st_ff.rd_valid;
  assign spi_error = st_ff.spi_err;
  assign main_regulator_output = st_ff.reg_on;
  assign mcu_reset_b = st_ff.mcu_rst_b;
  assign operating_state = st_ff.state;
  assign operating_state_select = st_ff.sel;
  assign dev_mode = ctl.dev_mode;
endmodule
`default_nettype wire

// *** tb/sbcmo_checker.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Port-level checks of the operating-mode machine
module sbcmo_checker #(
  parameter int WAKE_W = 3
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // Frames and events
  input wire logic spi_frame_valid,
  input wire logic [15:0] spi_frame,
  input wire logic spi_rd_valid,
  input wire logic can_wake,
  input wire logic lin_wake,
  input wire logic [WAKE_W-1:0] wake_inputs,
  input wire logic regulator_uv,
  input wire logic overtemp,
  // Supply, reset and status
  input wire logic main_regulator_output,
  input wire logic mcu_reset_b,
  input wire logic [2:0] operating_state,
  input wire logic [1:0] operating_state_select,
  input wire logic dev_mode
);
  logic wake;
  logic [10:0] rs_cnt_ff;
  logic [10:0] nxt_rs_cnt;
  // Delay counter leaves on zero, so a clean stay ends at this count
  localparam logic [10:0] RS_LAST = 11'(sbcmo_pkg::RESET_DELAY_CYC - 1);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ==========================================================
  // Helpers
  assign wake = can_wake | lin_wake | (|wake_inputs);
  // Undervoltage restarts the count, so uv-free Restart time only
  always_comb
  begin
    nxt_rs_cnt = 11'h0;
    if (operating_state == 3'h4 && !regulator_uv)
      nxt_rs_cnt = rs_cnt_ff + 11'h1;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      rs_cnt_ff <= 11'h0;
    else
      rs_cnt_ff <= nxt_rs_cnt;
  end
  // ==========================================================
  // Sequences
  sequence s_mode_wr(sel);
    spi_frame_valid && spi_frame[7] && !overtemp && !regulator_uv &&
      spi_frame[6:0] == sbcmo_pkg::ADDR_MODE_CTRL &&
      spi_frame[15:14] == sel;
  endsequence
  sequence s_init_frame;
    operating_state == 3'h0 && spi_frame_valid && !overtemp &&
      !regulator_uv && !(spi_frame[7] && spi_frame[15:14] == 2'h3);
  endsequence
  // ==========================================================
  // Properties
  property p_rd_valid;
    spi_frame_valid |=> spi_rd_valid;
  endproperty
  a_rd_valid: assert property (p_rd_valid)
    else $error("answer strobe missing");
  property p_legal;
    operating_state <= 3'h5;
  endproperty
  a_legal: assert property (p_legal)
    else $error("state code out of range");
  property p_stop_on;
    operating_state == 3'h2 |-> main_regulator_output;
  endproperty
  a_stop_on: assert property (p_stop_on)
    else $error("regulator off in Stop");
  property p_sleep_off;
    operating_state == 3'h3 |-> !main_regulator_output;
  endproperty
  a_sleep_off: assert property (p_sleep_off)
    else $error("regulator on in Sleep");
  property p_sleep_wake;
    operating_state == 3'h3 && wake && !overtemp |=>
      operating_state == 3'h4 && !mcu_reset_b;
  endproperty
  a_sleep_wake: assert property (p_sleep_wake)
    else $error("wake in Sleep did not restart");
  property p_rs_hold;
    operating_state == 3'h4 && rs_cnt_ff < RS_LAST && !overtemp |=>
      operating_state == 3'h4;
  endproperty
  a_rs_hold: assert property (p_rs_hold)
    else $error("Restart left early");
  property p_rs_exit;
    $past(operating_state) == 3'h4 && operating_state == 3'h1 |->
      $past(rs_cnt_ff) == RS_LAST && mcu_reset_b;
  endproperty
  a_rs_exit: assert property (p_rs_exit)
    else $error("Restart length wrong");
  property p_fs_off;
    operating_state == 3'h5 |-> !main_regulator_output;
  endproperty
  a_fs_off: assert property (p_fs_off)
    else $error("regulator on in Fail-Safe");
  property p_fs_hold;
    operating_state == 3'h5 && !wake && overtemp |=> operating_state == 3'h5;
  endproperty
  a_fs_hold: assert property (p_fs_hold)
    else $error("Fail-Safe left without cause");
  property p_sleep_req;
    operating_state == 3'h1 ##0 s_mode_wr(sbcmo_pkg::SEL_SLEEP) |=>
      operating_state == 3'h3 && operating_state_select == 2'h1;
  endproperty
  a_sleep_req: assert property (p_sleep_req)
    else $error("Sleep request not taken");
  property p_rs_sel;
    operating_state == 3'h4 && $past(operating_state) == 3'h4 |->
      operating_state_select == 2'h0;
  endproperty
  a_rs_sel: assert property (p_rs_sel)
    else $error("select field not cleared");
  property p_init_frame;
    s_init_frame |=> operating_state == 3'h1;
  endproperty
  a_init_frame: assert property (p_init_frame)
    else $error("frame in Init did not reach Normal");
  property p_dev_frozen;
    operating_state != 3'h0 && $past(operating_state) != 3'h0 |->
      $stable(dev_mode);
  endproperty
  a_dev_frozen: assert property (p_dev_frozen)
    else $error("development mode changed outside Init");
endmodule
bind sbc_operating_mode_fsm sbcmo_checker #(.WAKE_W(WAKE_W)) u_chk (.*);
`default_nettype wire

// *** tb/sbcmo_host_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Host side: issues whole 16-bit frames, one strobe each
module sbcmo_host_model (
  // Clock
  input wire logic clk,
  // Frame strobe and word
  output logic spi_frame_valid,
  output logic [15:0] spi_frame
);
  initial
  begin
    spi_frame_valid = 1'h0;
    spi_frame = 16'h5a5a;
  end
  // Word is inverted after the strobe so a stale copy never matches
  task automatic send(input logic [15:0] f);
    @(posedge clk);
    spi_frame_valid <= 1'h1;
    spi_frame <= f;
    @(posedge clk);
    spi_frame_valid <= 1'h0;
    spi_frame <= ~f;
  endtask
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none
// ==========================================================
// Mode machine bench, watchdog windows shortened
module tb_top;
  logic clk, rst_b, spi_frame_valid, spi_rd_valid, spi_error;
  logic can_wake, lin_wake, regulator_uv, overtemp;
  logic debug_strap_n, cfg_strap, main_regulator_output;
  logic mcu_reset_b, dev_mode;
  logic [15:0] spi_frame, spi_rd_data;
  logic [2:0] wake_inputs, operating_state;
  logic [1:0] operating_state_select;
  int n_mismatch = 0;
  int check_count = 0;
  int waited;
  sbcmo_host_model u_host (.clk(clk), .spi_frame_valid(spi_frame_valid),
    .spi_frame(spi_frame));
  sbc_operating_mode_fsm #(.WAKE_W(3), .LONG_WIN(200), .WD_PERIOD(100))
    DUT (.clk(clk), .rst_b(rst_b), .spi_frame_valid(spi_frame_valid),
    .spi_frame(spi_frame), .spi_rd_data(spi_rd_data),
    .spi_rd_valid(spi_rd_valid), .spi_error(spi_error),
    .can_wake(can_wake), .lin_wake(lin_wake), .wake_inputs(wake_inputs),
    .regulator_uv(regulator_uv), .overtemp(overtemp),
    .debug_strap_n(debug_strap_n), .cfg_strap(cfg_strap),
    .main_regulator_output(main_regulator_output),
    .mcu_reset_b(mcu_reset_b), .operating_state(operating_state),
    .operating_state_select(operating_state_select), .dev_mode(dev_mode));
  // Clock
  initial
  begin
    clk = 1'h0;
    forever #5 clk = ~clk;
  end
  // ==========================================================
  // Helpers
  task automatic chk(input string nm, input logic [15:0] e,
    input logic [15:0] g);
    check_count++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic chk_st(input logic [2:0] e);
    chk("state", 16'(e), 16'(operating_state));
  endtask
  task automatic results();
    $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // Bounded wait; a timeout ends the run
  task automatic wait_st(input logic [2:0] s, input int lim);
    waited = 0;
    while (operating_state !== s)
    begin
      @(posedge clk);
      #1;
      waited++;
      if (waited > lim)
      begin
        chk("wait state", 16'(s), 16'(operating_state));
        results();
      end
    end
  endtask
  task automatic pulse_can();
    @(posedge clk);
    can_wake <= 1'h1;
    @(posedge clk);
    can_wake <= 1'h0;
    #1;
  endtask
  // ==========================================================
  // Scenarios
  task automatic t_init_wd();
    chk_st(3'h0);
    chk("regulator", 16'h1, 16'(main_regulator_output));
    chk("select", 16'h0, 16'(operating_state_select));
    pulse_can();
    chk_st(3'h0);
    wait_st(3'h4, 260);
    chk("mcu reset", 16'h0, 16'(mcu_reset_b));
    wait_st(3'h1, 1100);
    chk("restart cycles", 16'(sbcmo_pkg::RESET_DELAY_CYC), 16'(waited));
    chk("mcu reset", 16'h1, 16'(mcu_reset_b));
  endtask
  task automatic t_sleep_wake();
    u_host.send(16'h4081);
    #1;
    chk_st(3'h3);
    chk("answer strobe", 16'h1, 16'(spi_rd_valid));
    chk("select", 16'h1, 16'(operating_state_select));
    chk("frame error", 16'h0, 16'(spi_error));
    chk("regulator", 16'h0, 16'(main_regulator_output));
    @(posedge clk);
    lin_wake <= 1'h1;
    @(posedge clk);
    lin_wake <= 1'h0;
    #1;
    chk_st(3'h4);
    @(posedge clk);
    #1;
    chk("select", 16'h0, 16'(operating_state_select));
    wait_st(3'h1, 1100);
  endtask
  task automatic t_stop();
    u_host.send(16'h8081);
    u_host.send(16'h0082);
    #1;
    chk_st(3'h2);
    chk("regulator", 16'h1, 16'(main_regulator_output));
    @(posedge clk);
    regulator_uv <= 1'h1;
    @(posedge clk);
    regulator_uv <= 1'h0;
    #1;
    chk_st(3'h4);
    wait_st(3'h1, 1100);
  endtask
  task automatic t_failsafe();
    @(posedge clk);
    overtemp <= 1'h1;
    repeat (6) @(posedge clk);
    #1;
    chk_st(3'h5);
    chk("regulator", 16'h0, 16'(main_regulator_output));
    @(posedge clk);
    overtemp <= 1'h0;
    repeat (3) @(posedge clk);
    #1;
    chk("left", 16'h1, 16'(operating_state != 3'h5));
    wait_st(3'h1, 1100);
  endtask
  task automatic t_dev();
    @(posedge clk);
    debug_strap_n <= 1'h0;
    u_host.send(16'hc081);
    #1;
    chk_st(3'h0);
    u_host.send(16'h007f);
    #1;
    chk_st(3'h1);
    chk("frame error", 16'h1, 16'(spi_error));
    chk("dev mode", 16'h1, 16'(dev_mode));
    @(posedge clk);
    debug_strap_n <= 1'h1;
    repeat (400) @(posedge clk);
    #1;
    chk_st(3'h1);
  endtask
  task automatic t_wd_fs();
    @(posedge clk);
    cfg_strap <= 1'h0;
    u_host.send(16'hc081);
    u_host.send(16'h0040);
    #1;
    chk("dev mode", 16'h0, 16'(dev_mode));
    chk("status read", 16'h0040, spi_rd_data);
    wait_st(3'h5, 400);
    chk("regulator", 16'h0, 16'(main_regulator_output));
    // Wake pin 2 this time, so CAN, LIN and one of the three wake pins are each driven once
    @(posedge clk);
    wake_inputs <= 3'h4;
    @(posedge clk);
    wake_inputs <= 3'h0;
    #1;
    chk_st(3'h4);
    wait_st(3'h1, 1100);
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    rst_b = 1'h0;
    can_wake = 1'h0;
    lin_wake = 1'h0;
    wake_inputs = 3'h0;
    regulator_uv = 1'h0;
    overtemp = 1'h0;
    debug_strap_n = 1'h1;
    cfg_strap = 1'h1;
    repeat (3) @(posedge clk);
    rst_b <= 1'h1;
    #1;
    t_init_wd();
    t_sleep_wake();
    t_stop();
    t_failsafe();
    t_dev();
    t_wd_fs();
    results();
  end
endmodule
`default_nettype wire
